// File: logic/amc_pkg.sv
// package for the converter mux and conversion control block
// assumes a 32-bit AHB-Lite slave with word-aligned registers
package amc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_PAIR_CFG = 8'h08;
  localparam logic [7:0] OFF_CHANNEL = 8'h0C;
  localparam logic [7:0] OFF_PORT3_SEL = 8'h10;
  localparam logic [7:0] OFF_HV_AMP = 8'h14;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h18;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h1C;
  localparam logic [7:0] OFF_SAR_DATA = 8'h20;
  // control register fields
  localparam int CTL_ENABLE = 7;
  localparam int CTL_TRACK = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_SRC_HI = 3;
  localparam int CTL_SRC_LO = 2;
  localparam int CTL_LJUST = 0;
  // config register fields
  localparam int CFG_DIV_HI = 7;
  localparam int CFG_DIV_LO = 3;
  // hv amp control fields
  localparam int HV_EN = 7;
  localparam int HV_GAIN_HI = 3;
  // pair config fields
  localparam int PAIR_AIN01 = 0;
  localparam int PAIR_AIN23 = 1;
  localparam int PAIR_HV = 2;
  localparam int PAIR_P3 = 3;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'hF8;
  localparam logic [7:0] RST_PAIR_CFG = 8'h00;
  localparam logic [7:0] RST_CHANNEL = 8'h00;
  localparam logic [7:0] RST_PORT3_SEL = 8'h00;
  localparam logic [7:0] RST_HV_AMP = 8'h00;
  // timing counts in conversion clocks
  localparam int LP_TRACK_CLOCKS = 3;
  localparam int CONV_CLOCKS = 11;
  // start source encodings
  typedef enum logic [1:0] {
    AMC_SRC_BUSY = 2'b00,
    AMC_SRC_TMR3 = 2'b01,
    AMC_SRC_STROBE = 2'b10,
    AMC_SRC_TMR2 = 2'b11
  } amc_src_t;
  // mux selections driven to the analog side
  typedef enum logic [3:0] {
    AMC_SEL_AIN0 = 4'h0,
    AMC_SEL_AIN1 = 4'h1,
    AMC_SEL_AIN2 = 4'h2,
    AMC_SEL_AIN3 = 4'h3,
    AMC_SEL_HVAMP = 4'h4,
    AMC_SEL_AGND = 4'h5,
    AMC_SEL_PORT3_EVEN_NODE = 4'h6,
    AMC_SEL_PORT3_ODD_NODE = 4'h7,
    AMC_SEL_TEMP = 4'h8
  } amc_sel_t;
  // negative input selections
  localparam logic [2:0] NEG_AGND = 3'h0;
  localparam logic [2:0] NEG_AIN1 = 3'h1;
  localparam logic [2:0] NEG_AIN3 = 3'h2;
  localparam logic [2:0] NEG_HV_COMMON_REF = 3'h3;
  localparam logic [2:0] NEG_PORT3_ODD_NODE = 3'h4;
endpackage : amc_pkg

// File: logic/amc_clkdiv.sv
// conversion clock divider: one-cycle tick every div+1 system clocks
// assumes div is stable while the converter runs
`timescale 1ns/1ps
module amc_clkdiv
  import amc_pkg::*;
#(
  parameter int DIV_WIDTH = 5
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [DIV_WIDTH-1:0] div,
  output logic tick
);
  logic [DIV_WIDTH-1:0] count;
  wire wrap = (count >= div);
  wire [DIV_WIDTH-1:0] next_count = wrap ? '0 : count + 1'b1;

  // count system clocks, tick on wrap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= run ? next_count : '0;
      tick <= run & wrap;
    end
  end
endmodule : amc_clkdiv

// File: logic/amc_top.sv
// converter mux decode, port 3 pin enables, hv amp control, and
// conversion sequencing behind an AHB-Lite slave
// assumes one 125 MHz clock; the SAR core returns a 10-bit code
// What this block does
// - channel code 0-3 ain, 4 amp, 5 ground, 6 even, 7 odd, 1xxx temp
// - even and odd nodes carry enabled even or odd port 3 pins
// - differential amp channel applies common reference to negative input
// - each port 3 select bit routes its pin; any number; reset zero
// - amp control holds enable bit and gain code field
// - start from busy write, timer 3, strobe rise or timer 2
// - busy reads one during conversion, zero after
// - busy falling sets done flag bit 5; software clears it
// - result placed in high and low registers per justify bit
// - low-power bit clear: track continuously when not converting
// - low-power bit set: track 3 conversion clocks, then convert
// - low-power strobe mode: track while strobe low, convert on rise
// - conversion clock is system clock divided by divider field plus one
// - tracking may stop while chip sleeps
// - conversion clock equals system clock over divider plus one
// - differential results in two's complement
// - right justified high bits 7-2 sign extend or zero
// - all input pairs single ended after reset
`timescale 1ns/1ps
module amc_top
  import amc_pkg::*;
#(
  parameter int RES_BITS = 10
)(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TIMER3_OVERFLOW,
  input wire logic TIMER2_OVERFLOW,
  input wire logic EXT_CONVERT_STROBE,
  input wire logic CHIP_SLEEP,
  input wire logic [RES_BITS-1:0] SAR_CODE,
  output logic [3:0] MUX_POS_SEL,
  output logic [2:0] MUX_NEG_SEL,
  output logic [7:0] PORT3_EVEN_NODE_EN,
  output logic [7:0] PORT3_ODD_NODE_EN,
  output logic HV_AMP_ENABLE,
  output logic [3:0] HV_GAIN_CODE,
  output logic CONVERTER_ENABLE,
  output logic TRACK,
  output logic SAMPLE,
  output logic CONV_DONE_IRQ
);
  typedef enum logic [1:0] {
    AMC_IDLE,
    AMC_LPTRACK,
    AMC_CONVERT
  } amc_state_t;

  logic [7:0] converter_control;
  logic [7:0] converter_config;
  logic [3:0] input_pair_config;
  logic [3:0] mux_channel_code;
  logic [7:0] port3_analog_pin_select;
  logic [7:0] hv_amp_control;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_data;
  amc_state_t state;
  logic [3:0] sar_count;
  logic strobe_q;
  logic conv_diff;
  logic busy_q;

  // bus address phase decode
  wire bus_take = HSEL & HREADY & HTRANS[1];
  wire [7:0] rd_addr = {HADDR[7:2], 2'b00};
  wire wr_ctl = wr_pend & (wr_addr == OFF_CONTROL);
  wire [7:0] wbyte = HWDATA[7:0];
  wire [1:0] src = converter_control[CTL_SRC_HI:CTL_SRC_LO];
  wire lp_mode = converter_control[CTL_TRACK];
  wire enabled = converter_control[CTL_ENABLE];

  // start event selection
  wire strobe_rise = EXT_CONVERT_STROBE & ~strobe_q;
  wire sw_start = wr_ctl & wbyte[CTL_BUSY]
                & (src == AMC_SRC_BUSY);
  wire start_evt = enabled & (sw_start
                 | ((src == AMC_SRC_TMR3) & TIMER3_OVERFLOW)
                 | ((src == AMC_SRC_STROBE) & strobe_rise)
                 | ((src == AMC_SRC_TMR2) & TIMER2_OVERFLOW));
  // a start while busy is dropped so busy cannot outlive the sequencer
  wire start_ok = start_evt & (state == AMC_IDLE);
  wire run_div = enabled & (state != AMC_IDLE);
  wire sar_tick;

  // conversion clock from divider field plus one
  amc_clkdiv #(
    .DIV_WIDTH(5)
  ) u_div (
    .clk(CLOCK),
    .rst(RST),
    .run(run_div),
    .div(converter_config[CFG_DIV_HI:CFG_DIV_LO]),
    .tick(sar_tick)
  );

  // mux decode of channel code and pair config
  wire ch_temp = mux_channel_code[3];
  wire [2:0] ch = mux_channel_code[2:0];
  wire pair01 = input_pair_config[PAIR_AIN01];
  wire pair23 = input_pair_config[PAIR_AIN23];
  wire pair_hv = input_pair_config[PAIR_HV];
  wire pair_p3 = input_pair_config[PAIR_P3];
  wire is_diff = ~ch_temp & (((ch[2:1] == 2'b00) & pair01)
               | ((ch[2:1] == 2'b01) & pair23)
               | ((ch[2:1] == 2'b10) & pair_hv)
               | ((ch[2:1] == 2'b11) & pair_p3));
  wire [3:0] pos_sel = ch_temp ? AMC_SEL_TEMP
                     : (is_diff ? {1'b0, ch[2:1], 1'b0}
                     : {1'b0, ch});
  wire [2:0] neg_sel = ~is_diff ? NEG_AGND
                     : (ch[2:1] == 2'b00) ? NEG_AIN1
                     : (ch[2:1] == 2'b01) ? NEG_AIN3
                     : (ch[2:1] == 2'b10) ? NEG_HV_COMMON_REF
                     : NEG_PORT3_ODD_NODE;

  // result justification and sign handling
  wire [9:0] code = SAR_CODE[9:0];
  wire sgn = conv_diff & code[9];
  wire [7:0] next_high = converter_control[CTL_LJUST] ? code[9:2]
                       : {{6{sgn}}, code[9:8]};
  wire [7:0] next_low = converter_control[CTL_LJUST]
                      ? {code[1:0], 6'h00} : code[7:0];

  // read data selection from the address phase
  always_comb
  begin
    case (rd_addr)
      OFF_CONTROL: rd_data = converter_control;
      OFF_CONFIG: rd_data = converter_config;
      OFF_PAIR_CFG: rd_data = {4'h0, input_pair_config};
      OFF_CHANNEL: rd_data = {4'h0, mux_channel_code};
      OFF_PORT3_SEL: rd_data = port3_analog_pin_select;
      OFF_HV_AMP: rd_data = {hv_amp_control[HV_EN], 3'h0,
                             hv_amp_control[HV_GAIN_HI:0]};
      OFF_RESULT_HIGH: rd_data = result_high;
      OFF_RESULT_LOW: rd_data = result_low;
      default: rd_data = 8'h00;
    endcase
  end

  // bus phase tracking; slave is always ready
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (HREADY)
    begin
      wr_pend <= bus_take & HWRITE;
      wr_addr <= bus_take ? {HADDR[7:2], 2'b00} : wr_addr;
    end
  end

  // read data registered at end of address phase
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      if (bus_take & ~HWRITE)
        HRDATA <= {24'h000000, rd_data};
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      converter_config <= RST_CONFIG;
      input_pair_config <= RST_PAIR_CFG[3:0];
      mux_channel_code <= RST_CHANNEL[3:0];
      port3_analog_pin_select <= RST_PORT3_SEL;
      hv_amp_control <= RST_HV_AMP;
    end
    else if (wr_pend)
    begin
      if (wr_addr == OFF_CONFIG)
        converter_config <= wbyte;
      if (wr_addr == OFF_PAIR_CFG)
        input_pair_config <= wbyte[3:0];
      if (wr_addr == OFF_CHANNEL)
        mux_channel_code <= wbyte[3:0];
      if (wr_addr == OFF_PORT3_SEL)
        port3_analog_pin_select <= wbyte;
      if (wr_addr == OFF_HV_AMP)
        hv_amp_control <= {wbyte[HV_EN], 3'h0, wbyte[HV_GAIN_HI:0]};
    end
  end

  // done flag: set by busy falling wins over software clear
  wire busy_fall = busy_q & ~converter_control[CTL_BUSY];
  wire done_clr = wr_ctl & ~wbyte[CTL_DONE];
  wire done_set = wr_ctl & wbyte[CTL_DONE];
  wire next_done = busy_fall | (converter_control[CTL_DONE] & ~done_clr)
                 | done_set;
  wire conv_end = (state == AMC_CONVERT) & sar_tick
                & (sar_count == 4'(CONV_CLOCKS - 1));
  wire next_busy = start_ok | (converter_control[CTL_BUSY]
                 & ~conv_end & enabled);

  // control register
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      converter_control <= RST_CONTROL;
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= converter_control[CTL_BUSY];
      converter_control[CTL_BUSY] <= next_busy;
      converter_control[CTL_DONE] <= next_done;
      if (wr_ctl)
      begin
        converter_control[7:6] <= wbyte[7:6];
        converter_control[3:0] <= wbyte[3:0];
      end
    end
  end

  // conversion sequencer
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state <= AMC_IDLE;
      sar_count <= 4'h0;
      conv_diff <= 1'b0;
    end
    else if (!enabled)
    begin
      state <= AMC_IDLE;
      sar_count <= 4'h0;
    end
    else
    begin
      case (state)
        AMC_IDLE:
          if (start_evt)
          begin
            conv_diff <= is_diff;
            sar_count <= 4'h0;
            // strobe mode already tracked while low
            state <= (lp_mode & (src != AMC_SRC_STROBE)) ? AMC_LPTRACK
                   : AMC_CONVERT;
          end
        AMC_LPTRACK:
          if (sar_tick)
          begin
            if (sar_count == 4'(LP_TRACK_CLOCKS - 1))
            begin
              sar_count <= 4'h0;
              state <= AMC_CONVERT;
            end
            else
              sar_count <= sar_count + 4'h1;
          end
        AMC_CONVERT:
          if (sar_tick)
          begin
            sar_count <= conv_end ? 4'h0 : sar_count + 4'h1;
            state <= conv_end ? AMC_IDLE : AMC_CONVERT;
          end
        default: state <= AMC_IDLE;
      endcase
    end
  end

  // track qualifier per mode
  wire next_track = enabled & ~CHIP_SLEEP
    & (lp_mode ? ((src == AMC_SRC_STROBE) ? (~EXT_CONVERT_STROBE
                   & (state == AMC_IDLE))
                 : (state == AMC_LPTRACK))
       : (state != AMC_CONVERT));

  // results, strobe edge history and registered analog controls
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      result_high <= 8'h00;
      result_low <= 8'h00;
      strobe_q <= 1'b0;
      MUX_POS_SEL <= 4'h0;
      MUX_NEG_SEL <= 3'h0;
      PORT3_EVEN_NODE_EN <= 8'h00;
      PORT3_ODD_NODE_EN <= 8'h00;
      HV_AMP_ENABLE <= 1'b0;
      HV_GAIN_CODE <= 4'h0;
      CONVERTER_ENABLE <= 1'b0;
      TRACK <= 1'b0;
      SAMPLE <= 1'b0;
      CONV_DONE_IRQ <= 1'b0;
    end
    else
    begin
      if (conv_end)
      begin
        result_high <= next_high;
        result_low <= next_low;
      end
      strobe_q <= EXT_CONVERT_STROBE;
      MUX_POS_SEL <= pos_sel;
      MUX_NEG_SEL <= neg_sel;
      PORT3_EVEN_NODE_EN <= port3_analog_pin_select & 8'h55;
      PORT3_ODD_NODE_EN <= port3_analog_pin_select & 8'hAA;
      HV_AMP_ENABLE <= hv_amp_control[HV_EN];
      HV_GAIN_CODE <= hv_amp_control[HV_GAIN_HI:0];
      CONVERTER_ENABLE <= enabled;
      TRACK <= next_track;
      SAMPLE <= enabled & (state == AMC_CONVERT);
      CONV_DONE_IRQ <= converter_control[CTL_DONE];
    end
  end
endmodule : amc_top

// File: testbench/amc_checker.sv
// port assertions for the converter mux and conversion control block
// assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/1ps
module amc_checker
  import amc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic CHIP_SLEEP,
  input wire logic [3:0] MUX_POS_SEL,
  input wire logic [2:0] MUX_NEG_SEL,
  input wire logic [7:0] PORT3_EVEN_NODE_EN,
  input wire logic [7:0] PORT3_ODD_NODE_EN,
  input wire logic CONVERTER_ENABLE,
  input wire logic TRACK,
  input wire logic SAMPLE,
  input wire logic CONV_DONE_IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // relations between mux, port 3, tracking and conversion outputs
  chk_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  chk_even_mask: assert property (
    (PORT3_EVEN_NODE_EN & 8'hAA) == 8'h00)
    else $error("odd pin routed to even node");
  chk_odd_mask: assert property (
    (PORT3_ODD_NODE_EN & 8'h55) == 8'h00)
    else $error("even pin routed to odd node");
  chk_mux_range: assert property (MUX_POS_SEL <= 4'h8)
    else $error("positive selection out of range");
  chk_neg_pairs: assert property (MUX_NEG_SEL != NEG_AGND |->
    MUX_NEG_SEL <= 3'h4 && MUX_POS_SEL == {MUX_NEG_SEL - 3'h1, 1'b0})
    else $error("negative input without its pair");
  chk_sample_len: assert property ($rose(SAMPLE) |-> SAMPLE [*8])
    else $error("conversion ended too early");
  chk_done_irq: assert property (
    $fell(SAMPLE) |-> ##[1:4] CONV_DONE_IRQ)
    else $error("no done after conversion end");
  chk_sample_enable: assert property (SAMPLE |-> CONVERTER_ENABLE)
    else $error("conversion while disabled");
  chk_sample_track: assert property (SAMPLE |-> !TRACK)
    else $error("tracking during conversion");
  chk_sleep_track: assert property (
    CHIP_SLEEP && $past(CHIP_SLEEP) |-> !TRACK)
    else $error("tracking while chip sleeps");
endmodule : amc_checker
bind amc_top amc_checker amc_checker_inst (.CLOCK, .RST, .HREADYOUT, .HRESP,
  .CHIP_SLEEP, .MUX_POS_SEL, .MUX_NEG_SEL, .PORT3_EVEN_NODE_EN,
  .PORT3_ODD_NODE_EN, .CONVERTER_ENABLE, .TRACK, .SAMPLE, .CONV_DONE_IRQ);

// File: testbench/amc_far_side.sv
// far side model: timer overflow pulses and the converter code source
// assumes start requests come from the bench as one-cycle pulses
`timescale 1ns/1ps
module amc_far_side #(
  parameter int MIN_GAP = 1250
)(
  input wire logic clk,
  input wire logic t3_req,
  input wire logic t2_req,
  input wire logic [9:0] code_req,
  output logic t3_pulse,
  output logic t2_pulse,
  output logic [9:0] sar_code
);
  int gap = MIN_GAP;
  logic p3 = 1'b0;
  logic p2 = 1'b0;
  // hold a request until start spacing keeps the rate legal, then pulse
  always @(posedge clk)
  begin
    t3_pulse <= 1'b0;
    t2_pulse <= 1'b0;
    gap <= gap + 1;
    if (t3_req) p3 <= 1'b1;
    if (t2_req) p2 <= 1'b1;
    if ((p3 || p2) && gap >= MIN_GAP)
    begin
      t3_pulse <= p3;
      t2_pulse <= p2;
      {p3, p2} <= 2'b00;
      gap <= 0;
    end
  end
  // converted code follows the measured analog value
  assign sar_code = code_req;
endmodule : amc_far_side

// File: testbench/adc_mux_and_conversion_control_tb_top.sv
// self-checking bench for the converter control block
// assumes the designer's zero-wait AHB-Lite slave and 125 MHz clock
`timescale 1ns/1ps
module adc_mux_and_conversion_control_tb_top
  import amc_pkg::*;
;
  logic CLOCK, RST, HSEL, HWRITE, HREADYOUT, HRESP, t3_req, t2_req;
  logic EXT_CONVERT_STROBE, CHIP_SLEEP, TIMER3_OVERFLOW, TIMER2_OVERFLOW;
  logic HV_AMP_ENABLE, CONVERTER_ENABLE, TRACK, SAMPLE, CONV_DONE_IRQ;
  logic [7:0] HADDR, PORT3_EVEN_NODE_EN, PORT3_ODD_NODE_EN, ctl, hi, sel;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, MUX_NEG_SEL;
  logic [31:0] HWDATA, HRDATA, rd;
  logic [9:0] SAR_CODE, code_req;
  logic [3:0] MUX_POS_SEL, HV_GAIN_CODE, ch, pc;
  logic [7:0] offs [6] = '{OFF_CONTROL, OFF_CONFIG, OFF_PAIR_CFG,
    OFF_CHANNEL, OFF_PORT3_SEL, OFF_HV_AMP};
  logic [7:0] rstv [6] = '{RST_CONTROL, RST_CONFIG, RST_PAIR_CFG,
    RST_CHANNEL, RST_PORT3_SEL, RST_HV_AMP};
  int n_errors = 0, checks_done = 0, busy_len = 0, track_len = 0, d, i;
  int base_busy, base_track;
  logic lp, lj, diff, seen;
  amc_top amc_top_inst (.CLOCK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .TIMER3_OVERFLOW, .TIMER2_OVERFLOW, .EXT_CONVERT_STROBE, .CHIP_SLEEP,
    .SAR_CODE, .MUX_POS_SEL, .MUX_NEG_SEL, .PORT3_EVEN_NODE_EN,
    .PORT3_ODD_NODE_EN, .HV_AMP_ENABLE, .HV_GAIN_CODE, .CONVERTER_ENABLE,
    .TRACK, .SAMPLE, .CONV_DONE_IRQ);
  amc_far_side amc_far_side_inst (.clk(CLOCK), .t3_req, .t2_req, .code_req,
    .t3_pulse(TIMER3_OVERFLOW), .t2_pulse(TIMER2_OVERFLOW),
    .sar_code(SAR_CODE));
  // system clock
  initial
  begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  // running totals of converting and tracking cycles
  always @(posedge CLOCK) if (SAMPLE) busy_len <= busy_len + 1;
  always @(posedge CLOCK) if (TRACK) track_len <= track_len + 1;
  // expected {negative, positive} mux selection
  function automatic logic [6:0] exp_mux(logic [3:0] c, logic [3:0] p);
    if (c[3]) return {NEG_AGND, 4'h8};
    case (c[2:1])
      2'd0: return p[0] ? {NEG_AIN1, 4'h0} : {NEG_AGND, c};
      2'd1: return p[1] ? {NEG_AIN3, 4'h2} : {NEG_AGND, c};
      2'd2: return p[2] ? {NEG_HV_COMMON_REF, 4'h4} : {NEG_AGND, c};
      default: return p[3] ? {NEG_PORT3_ODD_NODE, 4'h6} : {NEG_AGND, c};
    endcase
  endfunction : exp_mux
  // expected {high, low} result bytes
  function automatic logic [15:0] exp_res(logic [9:0] c, logic l, logic df);
    if (l) return {c, 6'h00};
    return df ? {{6{c[9]}}, c} : {6'h00, c};
  endfunction : exp_res
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    int k = 0;
    @(posedge CLOCK);
    while (HREADYOUT !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        chk(32'h0, 32'h1);
        complete_run();
      end
      @(posedge CLOCK);
    end
  endtask : wait_rdy
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= w;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    wait_rdy();
    rd = HRDATA;
  endtask : bus
  // main sequence
  initial
  begin
    {HSEL, HWRITE, t3_req, t2_req, EXT_CONVERT_STROBE, CHIP_SLEEP} = 6'h00;
    {HADDR, HTRANS, HWDATA, code_req} = '0;
    HSIZE = 3'h2;
    RST = 1'b1;
    void'($urandom(32'h3C73574C));
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      bus(1'b0, offs[i], 32'h0);
      chk(rd, {24'h0, rstv[i]});
    end
    bus(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    $display("reset values test done");
    for (i = 0; i < 16; i++)
    begin
      ch = i[3:0];
      pc = 4'($urandom);
      sel = 8'($urandom);
      hi = 8'($urandom);
      CHIP_SLEEP <= i[0];
      bus(1'b1, OFF_CHANNEL, {28'h0, ch});
      bus(1'b1, OFF_PAIR_CFG, {28'h0, pc});
      bus(1'b1, OFF_PORT3_SEL, {24'h0, sel});
      bus(1'b1, OFF_HV_AMP, {24'h0, hi});
      bus(1'b0, OFF_PORT3_SEL, 32'h0);
      chk(rd, {24'h0, sel});
      repeat (2) @(posedge CLOCK);
      chk({25'h0, MUX_NEG_SEL, MUX_POS_SEL}, {25'h0, exp_mux(ch, pc)});
      chk({PORT3_EVEN_NODE_EN, PORT3_ODD_NODE_EN}, {sel & 8'h55, sel & 8'hAA});
      chk({HV_AMP_ENABLE, HV_GAIN_CODE}, {hi[7], hi[3:0]});
    end
    CHIP_SLEEP <= 1'b0;
    $display("mux routing test done");
    for (i = 0; i < 8; i++)
    begin
      lp = i[2];
      lj = 1'($urandom);
      diff = 1'($urandom);
      d = 1 + $urandom % 4;
      code_req <= 10'($urandom);
      ctl = {1'b1, lp, 2'b00, i[1:0], 1'b0, lj};
      bus(1'b1, OFF_CHANNEL, 32'h0);
      bus(1'b1, OFF_PAIR_CFG, {31'h0, diff});
      bus(1'b1, OFF_CONFIG, {24'h0, 5'(d), 3'h0});
      bus(1'b1, OFF_CONTROL, {24'h0, ctl});
      repeat (3) @(posedge CLOCK);
      chk(TRACK, !lp || i[1:0] == 2'b10);
      bus(1'b0, OFF_CONTROL, 32'h0);
      chk(rd, {24'h0, ctl});
      repeat (1250) @(posedge CLOCK); // starts at most 100 ksps
      base_busy = busy_len;
      base_track = track_len;
      case (i[1:0])
        2'b00: bus(1'b1, OFF_CONTROL, {24'h0, ctl | 8'h10});
        2'b01: t3_req <= 1'b1;
        2'b10: EXT_CONVERT_STROBE <= 1'b1;
        default: t2_req <= 1'b1;
      endcase
      @(posedge CLOCK);
      {t3_req, t2_req} <= 2'b00;
      seen = 1'b0;
      rd = 32'h0;
      // poll the done flag, noting busy on the way
      for (int k = 0; k < 1000 && rd[5] !== 1'b1; k++)
      begin
        bus(1'b0, OFF_CONTROL, 32'h0);
        if (rd[4] === 1'b1) seen = 1'b1;
      end
      chk({seen, rd[5:4]}, 3'b110);
      if (rd[5] !== 1'b1) complete_run();
      chk(CONV_DONE_IRQ, 1'b1);
      hi = 8'((busy_len - base_busy) >= CONV_CLOCKS * (d + 1)
        && (busy_len - base_busy) <= CONV_CLOCKS * (d + 1) + 2);
      chk(hi, 8'h01);
      if (lp && i[1:0] != 2'b10)
      begin
        hi = 8'((track_len - base_track) >= LP_TRACK_CLOCKS * (d + 1)
          && (track_len - base_track) <= LP_TRACK_CLOCKS * (d + 1) + 2);
        chk(hi, 8'h01);
      end
      bus(1'b0, OFF_RESULT_HIGH, 32'h0);
      hi = rd[7:0];
      bus(1'b0, OFF_RESULT_LOW, 32'h0);
      chk({hi, rd[7:0]}, exp_res(code_req, lj, diff));
      EXT_CONVERT_STROBE <= 1'b0;
      bus(1'b1, OFF_CONTROL, {24'h0, ctl});
      bus(1'b0, OFF_CONTROL, 32'h0);
      chk(rd, {24'h0, ctl});
    end
    $display("conversion test done");
    complete_run();
  end
endmodule : adc_mux_and_conversion_control_tb_top
